/* dv/wmsd_checker_assertions.sv */
/* port assertions for wmsd_top.
   assumes one clock and async RSTN. */
`include "wmsd_map.vh"
`timescale 1ns/1ps
`default_nettype none
module wmsd_checker (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic ROM_TEST_OK,
    input wire logic RAM_TEST_OK,
    input wire logic DISP_LINK_OK,
    input wire logic MALFUNCTION,
    input wire logic HIGH_FLOW_OUT,
    input wire logic LOW_FLOW_OUT,
    input wire logic DIAG_PRESENT,
    input wire logic [7:0] DISP_DATA,
    input wire logic DISP_VALID,
    input wire logic DISP_READY
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    logic [4:0] cnt_q;
    logic bad_q;
    logic malf_q;
    wire outs_low = !HIGH_FLOW_OUT && !LOW_FLOW_OUT;
    wire all_ok = ROM_TEST_OK && RAM_TEST_OK && DISP_LINK_OK;
    // cycles since reset, saturating at 31
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q <= 5'h00;
            bad_q <= 1'b0;
            malf_q <= 1'b0;
        end else begin
            if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h0F && !all_ok) bad_q <= 1'b1;
            if (cnt_q > 5'h10 && MALFUNCTION) malf_q <= 1'b1;
        end
    end
    sequence s_stall;
        DISP_VALID && !DISP_READY;
    endsequence
    sequence s_prot_wr;
        REG_WR && REG_ADDR == `WMSD_OFS_PROT_CFG;
    endsequence
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
        else $error("idle rdata");
    a_test_outs_low: assert property (cnt_q < 5'h10 |-> outs_low)
        else $error("test outs");
    a_test_no_frame: assert property (cnt_q < 5'h10 |-> !DISP_VALID)
        else $error("test frame");
    a_fall_outs_low: assert property ($past(bad_q) |-> outs_low)
        else $error("fallback outs");
    a_malf_outs_low: assert property ($past(malf_q, 2) |-> outs_low)
        else $error("malf outs");
    a_disp_hold: assert property (s_stall |=> DISP_VALID && $stable(DISP_DATA))
        else $error("byte lost");
    a_diag_sticky: assert property (!DIAG_PRESENT |=> !DIAG_PRESENT)
        else $error("presence back");
    a_diag_cause: assert property ($fell(DIAG_PRESENT) |->
        $past(REG_WR) && $past(REG_ADDR) == `WMSD_OFS_PROT_CFG)
        else $error("presence cause");
    c_prot_refused: cover property (s_prot_wr ##1 !DIAG_PRESENT);
endmodule // wmsd_checker
bind wmsd_top wmsd_checker u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ROM_TEST_OK(ROM_TEST_OK),
    .RAM_TEST_OK(RAM_TEST_OK), .DISP_LINK_OK(DISP_LINK_OK), .MALFUNCTION(MALFUNCTION),
    .HIGH_FLOW_OUT(HIGH_FLOW_OUT), .LOW_FLOW_OUT(LOW_FLOW_OUT), .DIAG_PRESENT(DIAG_PRESENT),
    .DISP_DATA(DISP_DATA), .DISP_VALID(DISP_VALID), .DISP_READY(DISP_READY));
`default_nettype wire

/* dv/wmsd_tb_top.sv */
/* bench of wmsd_top with a terminal model.
   assumes short periods below. */
`include "wmsd_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module wmsd_tb_top;
    localparam int FLOW = 40;
    localparam int REP = 200;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ramp = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [23:0] raw = 24'h0;
    logic stable = 1'b1, ovl = 1'b0, unl = 1'b0, flt = 1'b0, seal = 1'b0, rom = 1'b1;
    logic malf = 1'b0, pwr = 1'b0, stall = 1'b0, hi, lo, diag, dvalid, dready;
    logic [7:0] ddata;
    logic [95:0] exp_txt;
    int errors = 0;
    int n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (ramp) raw <= raw + 24'h5;
    wmsd_top #(.FLOW_CYC(FLOW), .REPORT_CYC(REP), .FIFO_DEPTH(32)) uut (
        .REF_CLK(ref_clk), .RSTN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .WEIGHT_RAW(raw), .STABLE_IN(stable),
        .OVERLOAD_IN(ovl), .UNDERLOAD_IN(unl), .CHANNEL_FAULT_IN(flt), .SEAL_JUMPER(seal),
        .ROM_TEST_OK(rom), .RAM_TEST_OK(1'b1), .DISP_LINK_OK(1'b1), .MALFUNCTION(malf),
        .PWR_RESTORE(pwr), .HIGH_FLOW_OUT(hi), .LOW_FLOW_OUT(lo), .DIAG_PRESENT(diag),
        .DISP_DATA(ddata), .DISP_VALID(dvalid), .DISP_READY(dready));
    wmsd_term #(.TO_CYC(2 * REP)) u_term (.clk(ref_clk), .rst_n(rst_n), .data(ddata),
        .valid(dvalid), .stall(stall), .ready(dready));
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] ex);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, ex, rdata & m)
    endtask
    task automatic do_reset(input logic s, input logic ok);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        seal <= s;
        rom <= ok;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
    endtask
    task automatic wait_frames(input int n);
        int k;
        k = u_term.n_frm + n;
        for (int i = 0; i < 8 * REP && u_term.n_frm < k; i++) @(posedge ref_clk);
        if (u_term.n_frm < k) begin
            errors++;
            $display("BAD frame count exp %0d got %0d", k, u_term.n_frm);
            stop_test();
        end
    endtask
    task automatic t_display;
        raw <= 24'h00007B;
        wait_frames(2);
        `CHK("frame gap", REP, u_term.gap)
        exp_txt = "= +000123 kg";
        for (int i = 0; i < 12; i++) `CHK("frame byte", exp_txt[8*(11-i) +: 8], u_term.frm[i])
        raw <= 24'hFFFF85;
        wait_frames(2);
        `CHK("minus mark", 8'h2D, u_term.frm[2])
        for (int c = 0; c < 3; c++) begin
            flt <= (c == 0);
            ovl <= (c == 1);
            unl <= (c == 2);
            wait_frames(2);
            `CHK("fill first", c == 0 ? 8'h2D : c == 1 ? 8'h3E : 8'h3C, u_term.frm[3])
            `CHK("fill last", c == 0 ? 8'h2D : c == 1 ? 8'h3E : 8'h3C, u_term.frm[8])
        end
        unl <= 1'b0;
    endtask
    task automatic t_zero_power;
        `CHK("presence open", 1'b1, diag)
        expect_reg("seal bit", `WMSD_OFS_STATUS4, 32'h10, 32'h0);
        wr_reg(`WMSD_OFS_PROT_CFG, 32'h0001FF01);
        expect_reg("prot open", `WMSD_OFS_PROT_CFG, 32'h00FFFF3F, 32'h0001FF01);
        raw <= 24'h000064;
        wr_reg(`WMSD_OFS_CMD, `WMSD_CMD_ZERO);
        expect_reg("zero mem 1", `WMSD_OFS_ZERO_MEM, ALL, 32'h64);
        raw <= 24'h000096;
        wr_reg(`WMSD_OFS_CMD, `WMSD_CMD_ZERO);
        expect_reg("zero mem 2", `WMSD_OFS_ZERO_MEM, ALL, 32'h96);
        wr_reg(`WMSD_OFS_TARE, 32'h4D);
        expect_reg("tare flags", `WMSD_OFS_STATUS4, 32'h1100, 32'h1100);
        wr_reg(`WMSD_OFS_OPER_CFG, 32'h00030300);
        wr_reg(`WMSD_OFS_HIGH_CUT, 32'h1234);
        pwr <= 1'b1;
        @(posedge ref_clk);
        pwr <= 1'b0;
        expect_reg("zero kept", `WMSD_OFS_ZERO_MEM, ALL, 32'h96);
        expect_reg("tare kept", `WMSD_OFS_TARE, ALL, 32'h4D);
        expect_reg("oper lost", `WMSD_OFS_OPER_CFG, ALL, 32'h0);
        expect_reg("cut lost", `WMSD_OFS_HIGH_CUT, ALL, 32'h0);
        wr_reg(`WMSD_OFS_CMD, `WMSD_CMD_CALIB);
        expect_reg("zero cleared", `WMSD_OFS_ZERO_MEM, ALL, 32'h0);
        expect_reg("cal taken", `WMSD_OFS_DIAG, 32'h4, 32'h0);
        raw <= 24'h0;
        ramp <= 1'b1;
        repeat (4 * FLOW) @(posedge ref_clk);
        expect_reg("flow", `WMSD_OFS_FLOW, ALL, 5 * FLOW);
        ramp <= 1'b0;
    endtask
    task automatic t_sealed;
        do_reset(1'b1, 1'b1);
        expect_reg("seal bit", `WMSD_OFS_STATUS4, 32'h10, 32'h10);
        wr_reg(`WMSD_OFS_PROT_CFG, 32'h0002FF12);
        expect_reg("prot kept", `WMSD_OFS_PROT_CFG, ALL, `WMSD_PROT_RESET);
        `CHK("presence", 1'b0, diag)
        wr_reg(`WMSD_OFS_OPER_CFG, 32'h00030300);
        wr_reg(`WMSD_OFS_HIGH_CUT, 32'h1234);
        wr_reg(`WMSD_OFS_TARE, 32'h4D);
        expect_reg("oper open", `WMSD_OFS_OPER_CFG, 32'h00FFFF0F, 32'h00030300);
        expect_reg("cut open", `WMSD_OFS_HIGH_CUT, ALL, 32'h1234);
        expect_reg("tare open", `WMSD_OFS_TARE, ALL, 32'h4D);
        wr_reg(`WMSD_OFS_CMD, `WMSD_CMD_CALIB);
        expect_reg("cal refused", `WMSD_OFS_DIAG, 32'h6, 32'h6);
        wait_frames(2);
        `CHK("sealed frames", 0, u_term.n_bad)
        stall <= 1'b1;
        repeat (5 * REP) @(posedge ref_clk);
        `CHK("held byte", 1'b1, dvalid)
        `CHK("link timeout", 1'b1, u_term.to_err)
        stall <= 1'b0;
        for (int i = 0; i < REP && dvalid !== 1'b0; i++) @(posedge ref_clk);
        `CHK("drained", 1'b0, dvalid)
        wait_frames(2);
        `CHK("no byte lost", 0, u_term.n_bad)
    endtask
    task automatic t_fallback;
        do_reset(1'b0, 1'b0);
        expect_reg("fallback", `WMSD_OFS_DIAG, 32'h70, 32'h40);
        wait_frames(2);
        `CHK("fallback dash", 8'h2D, u_term.frm[3])
        do_reset(1'b0, 1'b1);
        expect_reg("run", `WMSD_OFS_DIAG, 32'hF0, 32'h20);
        malf <= 1'b1;
        @(posedge ref_clk);
        malf <= 1'b0;
        expect_reg("malfunction", `WMSD_OFS_DIAG, 32'hF0, 32'hC0);
        wait_frames(2);
        `CHK("malf dash", 8'h2D, u_term.frm[3])
        `CHK("outs low", 2'b00, {hi, lo})
    endtask
    initial begin
        do_reset(1'b0, 1'b1);
        t_display();
        t_zero_power();
        t_sealed();
        t_fallback();
        stop_test();
    end
endmodule // wmsd_tb_top
`default_nettype wire

/* dv/wmsd_term.sv */
/* display terminal model, checks frames.
   assumes the module clock. */
`timescale 1ns/1ps
`default_nettype none
module wmsd_term #(parameter int TO_CYC = 400) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic stall,
    output logic ready
);
    logic [7:0] buf_q [0:13];
    logic [7:0] frm [0:13];
    logic [7:0] sum;
    logic to_err;
    int idx, n_frm, n_bad, idle, t_now, t0, gap;
    assign ready = !stall;
    always @(posedge clk) begin
        t_now = t_now + 1;
        idle = idle + 1;
        if (!rst_n) begin
            idx = 0;
            idle = 0;
            to_err = 1'b0;
        end
        if (idle > TO_CYC) to_err = 1'b1;
        if (rst_n && valid && ready) begin
            idle = 0;
            if (idx == 0) begin
                gap = t_now - t0;
                t0 = t_now;
            end
            buf_q[idx] = data;
            idx = idx + 1;
            if (idx == 14) begin
                sum = 8'h00;
                for (int i = 0; i < 13; i++) sum = sum + buf_q[i];
                if (sum != 8'h00 || buf_q[13] != 8'h0D) n_bad = n_bad + 1;
                frm = buf_q;
                n_frm = n_frm + 1;
                idx = 0;
            end
        end
    end
endmodule // wmsd_term
`default_nettype wire

/* include/wmsd_map.vh */
/*
 * Offsets, fields, resets and timing counts of the weigh block.
 * Assumes a 50 ns clock.
 */
`ifndef WMSD_MAP_VH
`define WMSD_MAP_VH

`define WMSD_CLK_PERIOD_NS 50
`define WMSD_FLOW_PERIOD_MS 20
`define WMSD_REPORT_PERIOD_MS 100
`define WMSD_FLOW_CYC ((`WMSD_FLOW_PERIOD_MS * 1000000) / `WMSD_CLK_PERIOD_NS)
`define WMSD_REPORT_CYC ((`WMSD_REPORT_PERIOD_MS * 1000000) / `WMSD_CLK_PERIOD_NS)
`define WMSD_SELFTEST_CYC 16

`define WMSD_OFS_STATUS4 8'h00
`define WMSD_OFS_WEIGHT 8'h04
`define WMSD_OFS_FLOW 8'h08
`define WMSD_OFS_TARE 8'h0C
`define WMSD_OFS_ZERO_MEM 8'h10
`define WMSD_OFS_CMD 8'h14
`define WMSD_OFS_PROT_CFG 8'h18
`define WMSD_OFS_OPER_CFG 8'h1C
`define WMSD_OFS_HIGH_CUT 8'h20
`define WMSD_OFS_LOW_CUT 8'h24
`define WMSD_OFS_DIAG 8'h28
`define WMSD_OFS_TASK 8'h2C

`define WMSD_CMD_TARE 8'h01
`define WMSD_CMD_ZERO 8'h02
`define WMSD_CMD_CALIB 8'h03
`define WMSD_CMD_GROSS 8'h04

`define WMSD_PROT_RESET 32'h0001_0101
`define WMSD_OPER_RESET 32'h0000_0000

`define WMSD_ST4_HIGH 0
`define WMSD_ST4_LOW 1
`define WMSD_ST4_SEALED 4
`define WMSD_ST4_NET 8
`define WMSD_ST4_STABLE 9
`define WMSD_ST4_ZRANGE 10
`define WMSD_ST4_ZTRACK 11
`define WMSD_ST4_PRETARE 12

`define WMSD_PROT_UNIT_LSB 0
`define WMSD_PROT_ZTRACK 3
`define WMSD_PROT_DEC_LSB 4
`define WMSD_PROT_ZRANGE_LSB 8
`define WMSD_PROT_DIV_LSB 16

`define WMSD_OPER_THR_EN 0
`define WMSD_OPER_DIR 1
`define WMSD_OPER_ACT_LSB 2
`define WMSD_OPER_NFLOW_LSB 8
`define WMSD_OPER_MASK_LSB 16

`define WMSD_FRAME_LAST 4'd13

`endif

/* rtl/wmsd_top.v */
/*
 * Weigh module status, seal and report logic.
 * Assumes a 20 MHz REF_CLK and synchronous inputs;
 * DISP_DATA is drained under valid/ready.
 */
// Notes on behaviour
// - flow every 20 ms
// - report every 100 ms
// - report marks, value, unit
// - fault shows dashes
// - overload >, underload <
// - link tested at power-up
// - self-test fail: outputs low
// - malfunction: outputs low, dashes
// - tare, zero, task kept; oper cfg and cuts lost
// - zero memory sums offsets
// - sealed: protected read-only
// - open params writable
// - status bit 4 is seal
// - sealed: refuse, hide, report
// - sealed: no calibration
// - status bit layout
`include "wmsd_map.vh"
`timescale 1ns/1ps
`default_nettype none

module wmsd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // wmsd_fifo

module wmsd_top #(
    parameter FLOW_CYC = `WMSD_FLOW_CYC,
    parameter REPORT_CYC = `WMSD_REPORT_CYC,
    parameter FIFO_DEPTH = 32
) (
    input wire REF_CLK,
    input wire RSTN,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    input wire [23:0] WEIGHT_RAW,
    input wire STABLE_IN,
    input wire OVERLOAD_IN,
    input wire UNDERLOAD_IN,
    input wire CHANNEL_FAULT_IN,
    input wire SEAL_JUMPER,
    input wire ROM_TEST_OK,
    input wire RAM_TEST_OK,
    input wire DISP_LINK_OK,
    input wire MALFUNCTION,
    input wire PWR_RESTORE,
    output reg HIGH_FLOW_OUT,
    output reg LOW_FLOW_OUT,
    output wire DIAG_PRESENT,
    output wire [7:0] DISP_DATA,
    output wire DISP_VALID,
    input wire DISP_READY
);
    localparam ST_TEST = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_FALL = 3'b100;

    function [23:0] wmsd_abs;
        input [23:0] v;
        begin
            wmsd_abs = v[23] ? (~v + 24'h000001) : v;
        end
    endfunction

    function [23:0] wmsd_bcd6;
        input [23:0] mag;
        reg [19:0] bin;
        reg [23:0] bcd;
        integer i;
        integer j;
        begin
            bin = (mag > 24'h0F423F) ? 20'hF423F : mag[19:0];
            bcd = 24'h000000;
            for (i = 19; i >= 0; i = i - 1) begin
                for (j = 0; j < 6; j = j + 1) begin
                    if (bcd[j*4 +: 4] > 4'h4) begin
                        bcd[j*4 +: 4] = bcd[j*4 +: 4] + 4'h3;
                    end
                end
                bcd = {bcd[22:0], bin[i]};
            end
            wmsd_bcd6 = bcd;
        end
    endfunction

    reg [2:0] state_q;
    reg [4:0] test_cnt_q;
    reg sealed_q;
    reg malf_q;
    reg [31:0] prot_q;
    reg [31:0] oper_q;
    reg [31:0] task_q;
    reg [23:0] high_cut_q;
    reg [23:0] low_cut_q;
    reg [23:0] tare_q;
    reg [23:0] zero_mem_q;
    reg net_q;
    reg pretare_q;
    reg uncal_q;
    reg refused_q;
    reg cal_rej_q;
    reg [31:0] flow_tmr_q;
    reg [7:0] flow_per_q;
    reg [23:0] win_start_q;
    reg [23:0] flow_q;
    reg [7:0] mask_cnt_q;
    reg thr_en_q;
    reg [31:0] rep_tmr_q;
    reg busy_q;
    reg [3:0] idx_q;
    reg [7:0] sum_q;
    reg fr_stab_q;
    reg fr_net_q;
    reg [7:0] fr_sign_q;
    reg [1:0] fr_kind_q;
    reg [23:0] fr_bcd_q;
    reg [2:0] fr_unit_q;
    reg [1:0] fr_dec_q;
    reg [7:0] byte_d;
    reg [7:0] fchar;
    reg [2:0] k;
    reg [2:0] p;

    wire [23:0] gross = WEIGHT_RAW - zero_mem_q;
    wire [23:0] shown = net_q ? gross - tare_q : gross;
    wire [23:0] shown_mag = wmsd_abs(shown);
    wire in_zrange = wmsd_abs(gross) <= {16'h0000, prot_q[`WMSD_PROT_ZRANGE_LSB +: 8]};
    wire near_zero = shown_mag < {16'h0000, prot_q[`WMSD_PROT_DIV_LSB +: 8]};
    wire failed = (state_q != ST_RUN);
    wire flow_tick = (flow_tmr_q == FLOW_CYC - 1);
    wire rep_tick = (rep_tmr_q == REPORT_CYC - 1);
    wire [7:0] nflow = (oper_q[`WMSD_OPER_NFLOW_LSB +: 8] == 8'h00) ? 8'h01 :
        oper_q[`WMSD_OPER_NFLOW_LSB +: 8];
    wire wr_cmd = REG_WR && (REG_ADDR == `WMSD_OFS_CMD);
    wire [7:0] cmd = REG_WDATA[7:0];
    wire fifo_ready;
    wire push = busy_q && fifo_ready;
    wire [15:0] status4 = {3'b000, pretare_q, prot_q[`WMSD_PROT_ZTRACK], in_zrange,
        STABLE_IN, net_q, 3'b000, sealed_q, 2'b00, LOW_FLOW_OUT, HIGH_FLOW_OUT};

    assign DIAG_PRESENT = !refused_q;

    // self-test and fallback
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_TEST;
            test_cnt_q <= 5'h00;
            sealed_q <= 1'b0;
            malf_q <= 1'b0;
        end else begin
            case (state_q)
                ST_TEST: begin
                    sealed_q <= SEAL_JUMPER;
                    test_cnt_q <= test_cnt_q + 5'h01;
                    if (test_cnt_q == `WMSD_SELFTEST_CYC - 1) begin
                        if (ROM_TEST_OK && RAM_TEST_OK && DISP_LINK_OK) begin
                            state_q <= ST_RUN;
                        end else begin
                            state_q <= ST_FALL;
                        end
                    end
                end
                ST_RUN: begin
                    if (MALFUNCTION) begin
                        malf_q <= 1'b1;
                        state_q <= ST_FALL;
                    end
                end
                ST_FALL: begin
                    state_q <= ST_FALL;
                end
                default: begin
                    state_q <= ST_FALL;
                end
            endcase
        end
    end

    // machine params
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            prot_q <= `WMSD_PROT_RESET;
            tare_q <= 24'h000000;
            zero_mem_q <= 24'h000000;
            net_q <= 1'b0;
            pretare_q <= 1'b0;
            uncal_q <= 1'b1;
            refused_q <= 1'b0;
            cal_rej_q <= 1'b0;
        end else begin
            if (REG_WR && REG_ADDR == `WMSD_OFS_PROT_CFG) begin
                if (!sealed_q) begin
                    prot_q <= REG_WDATA;
                end else if (REG_WDATA != prot_q) begin
                    refused_q <= 1'b1;
                end
            end
            if (REG_WR && REG_ADDR == `WMSD_OFS_TARE) begin
                tare_q <= REG_WDATA[23:0];
                net_q <= 1'b1;
                pretare_q <= 1'b1;
            end
            if (wr_cmd) begin
                cal_rej_q <= (cmd == `WMSD_CMD_CALIB) && sealed_q;
                case (cmd)
                    `WMSD_CMD_TARE: begin
                        tare_q <= gross;
                        net_q <= 1'b1;
                        pretare_q <= 1'b0;
                    end
                    `WMSD_CMD_ZERO: begin
                        zero_mem_q <= zero_mem_q + gross;
                    end
                    `WMSD_CMD_CALIB: begin
                        if (!sealed_q) begin
                            zero_mem_q <= 24'h000000;
                            uncal_q <= 1'b0;
                        end
                    end
                    `WMSD_CMD_GROSS: begin
                        net_q <= 1'b0;
                    end
                    default: begin
                        net_q <= net_q;
                    end
                endcase
            end
        end
    end

    // operating params
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            oper_q <= `WMSD_OPER_RESET;
            task_q <= 32'h0000_0000;
            high_cut_q <= 24'h000000;
            low_cut_q <= 24'h000000;
        end else if (PWR_RESTORE) begin
            oper_q <= `WMSD_OPER_RESET;
            high_cut_q <= 24'h000000;
            low_cut_q <= 24'h000000;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `WMSD_OFS_OPER_CFG: oper_q <= REG_WDATA;
                `WMSD_OFS_TASK: task_q <= REG_WDATA;
                `WMSD_OFS_HIGH_CUT: high_cut_q <= REG_WDATA[23:0];
                `WMSD_OFS_LOW_CUT: low_cut_q <= REG_WDATA[23:0];
                default: task_q <= task_q;
            endcase
        end
    end

    // flow and thresholds
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flow_tmr_q <= 32'h0000_0000;
            flow_per_q <= 8'h00;
            win_start_q <= 24'h000000;
            flow_q <= 24'h000000;
            mask_cnt_q <= 8'h00;
            thr_en_q <= 1'b0;
            HIGH_FLOW_OUT <= 1'b0;
            LOW_FLOW_OUT <= 1'b0;
        end else begin
            flow_tmr_q <= flow_tick ? 32'h0000_0000 : flow_tmr_q + 32'h0000_0001;
            thr_en_q <= oper_q[`WMSD_OPER_THR_EN];
            if (oper_q[`WMSD_OPER_THR_EN] && !thr_en_q) begin
                mask_cnt_q <= oper_q[`WMSD_OPER_MASK_LSB +: 8];
            end else if (flow_tick && mask_cnt_q != 8'h00) begin
                mask_cnt_q <= mask_cnt_q - 8'h01;
            end
            if (flow_tick) begin
                if (flow_per_q + 8'h01 >= nflow) begin
                    flow_per_q <= 8'h00;
                    flow_q <= gross - win_start_q;
                    win_start_q <= gross;
                end else begin
                    flow_per_q <= flow_per_q + 8'h01;
                end
            end
            if (failed || !oper_q[`WMSD_OPER_THR_EN] || mask_cnt_q != 8'h00) begin
                HIGH_FLOW_OUT <= 1'b0;
                LOW_FLOW_OUT <= 1'b0;
            end else begin
                HIGH_FLOW_OUT <= oper_q[`WMSD_OPER_ACT_LSB] &&
                    (oper_q[`WMSD_OPER_DIR] ? ($signed(shown) > $signed(high_cut_q)) :
                    ($signed(shown) < $signed(high_cut_q)));
                LOW_FLOW_OUT <= oper_q[`WMSD_OPER_ACT_LSB + 1] &&
                    (oper_q[`WMSD_OPER_DIR] ? ($signed(shown) > $signed(low_cut_q)) :
                    ($signed(shown) < $signed(low_cut_q)));
            end
        end
    end

    // register reads
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `WMSD_OFS_STATUS4: REG_RDATA <= {16'h0000, status4};
                `WMSD_OFS_WEIGHT: REG_RDATA <= {{8{shown[23]}}, shown};
                `WMSD_OFS_FLOW: REG_RDATA <= {{8{flow_q[23]}}, flow_q};
                `WMSD_OFS_TARE: REG_RDATA <= {{8{tare_q[23]}}, tare_q};
                `WMSD_OFS_ZERO_MEM: REG_RDATA <= {{8{zero_mem_q[23]}}, zero_mem_q};
                `WMSD_OFS_PROT_CFG: REG_RDATA <= prot_q;
                `WMSD_OFS_OPER_CFG: REG_RDATA <= oper_q;
                `WMSD_OFS_HIGH_CUT: REG_RDATA <= {8'h00, high_cut_q};
                `WMSD_OFS_LOW_CUT: REG_RDATA <= {8'h00, low_cut_q};
                `WMSD_OFS_DIAG: REG_RDATA <= {24'h000000, malf_q, state_q, uncal_q,
                    cal_rej_q, refused_q, sealed_q};
                `WMSD_OFS_TASK: REG_RDATA <= task_q;
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    // report framing
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rep_tmr_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            idx_q <= 4'h0;
            sum_q <= 8'h00;
            fr_stab_q <= 1'b0;
            fr_net_q <= 1'b0;
            fr_sign_q <= 8'h20;
            fr_kind_q <= 2'b00;
            fr_bcd_q <= 24'h000000;
            fr_unit_q <= 3'b000;
            fr_dec_q <= 2'b00;
        end else begin
            rep_tmr_q <= rep_tick ? 32'h0000_0000 : rep_tmr_q + 32'h0000_0001;
            if (rep_tick && !busy_q && state_q != ST_TEST) begin
                busy_q <= 1'b1;
                idx_q <= 4'h0;
                sum_q <= 8'h00;
                fr_stab_q <= STABLE_IN;
                fr_net_q <= net_q;
                fr_sign_q <= near_zero ? 8'h6F : (shown[23] ? 8'h2D : 8'h2B);
                fr_kind_q <= (failed || CHANNEL_FAULT_IN) ? 2'd1 :
                    OVERLOAD_IN ? 2'd2 : (UNDERLOAD_IN ? 2'd3 : 2'd0);
                fr_bcd_q <= wmsd_bcd6(shown_mag);
                fr_unit_q <= prot_q[`WMSD_PROT_UNIT_LSB +: 3];
                fr_dec_q <= prot_q[`WMSD_PROT_DEC_LSB +: 2];
            end else if (push) begin
                sum_q <= sum_q + byte_d;
                idx_q <= idx_q + 4'h1;
                if (idx_q == `WMSD_FRAME_LAST) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // frame byte
    always @* begin
        k = 3'd0;
        p = 3'd6 - {1'b0, fr_dec_q};
        fchar = 8'h20;
        byte_d = 8'h20;
        if (idx_q >= 4'd3 && idx_q <= 4'd9) begin
            k = idx_q[2:0] - 3'd3;
            if (idx_q == 4'd3) begin
                k = 3'd0;
            end
            if (fr_dec_q != 2'b00 && k == p) begin
                fchar = 8'h2E;
            end else if (fr_dec_q != 2'b00 && k > p) begin
                fchar = 8'h30 + {4'h0, fr_bcd_q[(6 - k) * 4 +: 4]};
            end else if (k < 3'd6) begin
                fchar = 8'h30 + {4'h0, fr_bcd_q[(5 - k) * 4 +: 4]};
            end
            case (fr_kind_q)
                2'd1: fchar = 8'h2D;
                2'd2: fchar = 8'h3E;
                2'd3: fchar = 8'h3C;
                default: fchar = fchar;
            endcase
        end
        case (idx_q)
            4'd0: byte_d = fr_stab_q ? 8'h3D : 8'h20;
            4'd1: byte_d = fr_net_q ? 8'h4E : 8'h20;
            4'd2: byte_d = fr_sign_q;
            4'd10: byte_d = (fr_unit_q == 3'd0) ? 8'h67 : (fr_unit_q == 3'd1) ? 8'h6B :
                (fr_unit_q == 3'd2) ? 8'h6C : (fr_unit_q == 3'd3) ? 8'h6F : 8'h74;
            4'd11: byte_d = (fr_unit_q == 3'd1) ? 8'h67 : (fr_unit_q == 3'd2) ? 8'h62 :
                (fr_unit_q == 3'd3) ? 8'h7A : 8'h20;
            4'd12: byte_d = ~sum_q + 8'h01;
            4'd13: byte_d = 8'h0D;
            default: byte_d = fchar;
        endcase
    end

    wmsd_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .in_data(byte_d),
        .in_valid(busy_q),
        .in_ready(fifo_ready),
        .out_data(DISP_DATA),
        .out_valid(DISP_VALID),
        .out_ready(DISP_READY)
    );
endmodule // wmsd_top

`default_nettype wire
